// ### src/csml_top.sv
// Purpose: status output, startup defaults and thermistor handling
// Assumes: pins and comparator results arrive asynchronously
// Notes: host-side register bits are plain ports; no bus here
`timescale 1ns/1ps
`include "csml_defines.svh"
module csml_top
    import csml_pkg::*;
#(
    parameter int FAULT_PULSE_CYC = `CSML_FAULT_PULSE_CYC
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic source_usb_in,
    input wire logic charging_in,
    input wire logic charge_done_in,
    input wire logic charge_disabled_in,
    input wire logic fault_in,
    input wire logic stat_enable_in,
    input wire logic acc_enable_in,
    input wire logic host_programmed_in,
    input wire logic host_lost_in,
    input wire logic above_cold_in,
    input wire logic below_hot_in,
    input wire logic below_warm_in,
    input wire logic [`CSML_ICHG_W-1:0] host_ichg_ma_in,
    input wire logic [`CSML_ICHG_W-1:0] host_ilim_ma_in,
    input wire logic zone_fault_clear_in,
    output logic stat_out,
    output logic stat_oe_out,
    output logic acc_switch_on_out,
    output logic charge_suspend_out,
    output logic charge_reduce_out,
    output logic [`CSML_ICHG_W-1:0] input_limit_ma_out,
    output logic [`CSML_ICHG_W-1:0] charge_current_ma_out,
    output logic host_mode_out,
    output logic [1:0] zone_out,
    output logic zone_fault_out
);
    // synchronised pin and comparator inputs
    logic psel_s;
    logic cold_s;
    logic hot_s;
    logic warm_s;
    logic fault_s;

    csml_sync3 #(.RESET_VAL(1'b1)) u_psel (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in(source_usb_in),
        .sync_out(psel_s)
    );
    csml_sync3 u_cold (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in(above_cold_in),
        .sync_out(cold_s)
    );
    csml_sync3 u_hot (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in(below_hot_in),
        .sync_out(hot_s)
    );
    csml_sync3 u_warm (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in(below_warm_in),
        .sync_out(warm_s)
    );
    csml_sync3 u_fault (
        .clock_in(clock_in),
        .resetn_in(resetn_in),
        .async_in(fault_in),
        .sync_out(fault_s)
    );

    // decode comparators into one zone; cold and hot take priority
    function automatic csml_zone_t zone_of(input logic c, input logic h,
                                           input logic w);
        if (c) begin
            zone_of = CSML_ZONE_COLD;
        end else if (h) begin
            zone_of = CSML_ZONE_HOT;
        end else if (w) begin
            zone_of = CSML_ZONE_WARM;
        end else begin
            zone_of = CSML_ZONE_NORMAL;
        end
    endfunction

    csml_mode_t mode_q; // operating mode
    csml_zone_t zone_q; // registered zone
    logic zone_fault_q; // sticky zone fault for the host
    logic fault_d1_q; // previous fault level for edge detect
    logic [$clog2(FAULT_PULSE_CYC+1)-1:0] pulse_cnt_q; // pulse timer
    logic stat_low_q; // registered pin drive
    logic strap_done_q; // startup source captured
    logic [2:0] strap_cnt_q; // settle count before the strap is taken
    logic src_usb_q; // captured source at startup
    logic suspend_q;
    logic reduce_q;
    logic [`CSML_ICHG_W-1:0] ilim_q;
    logic [`CSML_ICHG_W-1:0] ichg_q;
    logic acc_q;
    csml_zone_t zone_d;

    assign zone_d = zone_of(cold_s, hot_s, warm_s);

    // mode selection
    // host programming moves to host mode; losing the host falls back
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_q <= CSML_MODE_DEFAULT;
        end else if (host_lost_in) begin
            mode_q <= CSML_MODE_DEFAULT;
        end else if (host_programmed_in) begin
            mode_q <= CSML_MODE_HOST;
        end
    end

    // source strap caught once after reset release; the synchroniser
    // still shows its reset value for a few cycles, so wait it out
    // or an adapter source would always start as usb
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            strap_cnt_q <= 3'h0;
            strap_done_q <= 1'b0;
            src_usb_q <= 1'b1;
        end else if (!strap_done_q) begin
            if (strap_cnt_q == 3'(`CSML_STRAP_SETTLE_CYC)) begin
                // settled: take the synchronised source level
                strap_done_q <= 1'b1;
                src_usb_q <= psel_s;
            end else begin
                strap_cnt_q <= strap_cnt_q + 3'h1;
            end
        end
    end

    // current defaults; host values replace them in host mode
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ilim_q <= `CSML_USB_ILIM_MA;
            ichg_q <= `CSML_USB_ICHG_MA;
        end else if (mode_q == CSML_MODE_HOST) begin
            ilim_q <= host_ilim_ma_in;
            ichg_q <= host_ichg_ma_in;
        end else if (src_usb_q) begin
            ilim_q <= `CSML_USB_ILIM_MA;
            ichg_q <= `CSML_USB_ICHG_MA;
        end else begin
            ilim_q <= `CSML_NO_ILIM_MA;
            ichg_q <= `CSML_ADP_ICHG_MA;
        end
    end

    // thermistor effect on charging, default mode only
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            suspend_q <= 1'b0;
            reduce_q <= 1'b0;
        end else if (mode_q == CSML_MODE_HOST) begin
            suspend_q <= 1'b0;
            reduce_q <= 1'b0;
        end else begin
            suspend_q <= (zone_d == CSML_ZONE_COLD) ||
                         (zone_d == CSML_ZONE_HOT);
            reduce_q <= (zone_d == CSML_ZONE_WARM);
        end
    end

    // zone status and sticky fault; a new fault wins over a clear
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            zone_q <= CSML_ZONE_NORMAL;
            zone_fault_q <= 1'b0;
        end else begin
            zone_q <= zone_d;
            if (zone_d != CSML_ZONE_NORMAL) begin
                zone_fault_q <= 1'b1;
            end else if (zone_fault_clear_in) begin
                zone_fault_q <= 1'b0;
            end
        end
    end

    // fault pulse timer, started on a rising fault edge
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fault_d1_q <= 1'b0;
            pulse_cnt_q <= '0;
        end else begin
            fault_d1_q <= fault_s;
            if (fault_s && !fault_d1_q) begin
                pulse_cnt_q <= ($bits(pulse_cnt_q))'(FAULT_PULSE_CYC);
            end else if (pulse_cnt_q != '0) begin
                pulse_cnt_q <= pulse_cnt_q - 1'b1;
            end
        end
    end

    // status pin drive; open drain, low when driven
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            stat_low_q <= 1'b0;
        end else if (!stat_enable_in) begin
            stat_low_q <= 1'b0;
        end else if (pulse_cnt_q != '0) begin
            // fault pulse shows as released-high during charge
            stat_low_q <= !charging_in;
        end else if (charge_done_in || charge_disabled_in) begin
            stat_low_q <= 1'b0;
        end else begin
            stat_low_q <= charging_in;
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= acc_enable_in;
        end
    end

    assign stat_out = 1'b0;
    assign stat_oe_out = stat_low_q;
    assign acc_switch_on_out = acc_q;
    assign charge_suspend_out = suspend_q;
    assign charge_reduce_out = reduce_q;
    assign input_limit_ma_out = ilim_q;
    assign charge_current_ma_out = ichg_q;
    assign host_mode_out = (mode_q == CSML_MODE_HOST);
    assign zone_out = zone_q;
    assign zone_fault_out = zone_fault_q;
endmodule

// ### src/csml_defines.svh
// Purpose: constants for the charger status and mode logic
// Assumes: 250 MHz core clock
// Notes: currents are in milliamps, times in nanoseconds
`ifndef CSML_DEFINES_SVH
`define CSML_DEFINES_SVH

`define CSML_CLK_PERIOD_NS 4
`define CSML_FAULT_PULSE_NS 128000
`define CSML_FAULT_PULSE_CYC (`CSML_FAULT_PULSE_NS / `CSML_CLK_PERIOD_NS)
`define CSML_USB_ILIM_MA 16'h0064
`define CSML_NO_ILIM_MA 16'hFFFF
`define CSML_ADP_ICHG_MA 16'h03E8
`define CSML_USB_ICHG_MA 16'h01F4
`define CSML_ICHG_W 16
// cycles after reset release before the source strap is trusted
`define CSML_STRAP_SETTLE_CYC 5

`endif

// ### src/csml_pkg.sv
// Purpose: shared types for the charger status and mode logic
// Assumes: nothing
// Notes: thermistor zones are mutually exclusive
package csml_pkg;
    // thermistor zone decoded from the comparators
    typedef enum logic [1:0] {
        CSML_ZONE_NORMAL,
        CSML_ZONE_WARM,
        CSML_ZONE_HOT,
        CSML_ZONE_COLD
    } csml_zone_t;
    // charger operating mode
    typedef enum logic {
        CSML_MODE_DEFAULT,
        CSML_MODE_HOST
    } csml_mode_t;
endpackage

// ### src/csml_sync3.sv
// Purpose: three-stage synchroniser with agreement on the last two stages
// Assumes: input is asynchronous to clock_in
// Notes: output only changes once stages two and three agree
`timescale 1ns/1ps
module csml_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_q; // first stage, read only by s2
    logic s2_q;
    logic s3_q;

    // shift chain
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a change only when two late stages agree
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync_out <= RESET_VAL;
        end else if (s2_q == s3_q) begin
            sync_out <= s3_q;
        end
    end
endmodule

// ### tb/csml_chk.sv
// Purpose: port checks for the charger status logic
// Assumes: one clock, async active-low reset
// Notes: a run counter times the fault pulse
`timescale 1ns/1ps
module csml_chk #(
    parameter int FAULT_PULSE_CYC = 32000
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic source_usb_in,
    input wire logic charging_in,
    input wire logic fault_in,
    input wire logic stat_enable_in,
    input wire logic acc_enable_in,
    input wire logic host_lost_in,
    input wire logic zone_fault_clear_in,
    input wire logic stat_oe_out,
    input wire logic acc_switch_on_out,
    input wire logic charge_suspend_out,
    input wire logic charge_reduce_out,
    input wire logic [15:0] input_limit_ma_out,
    input wire logic host_mode_out,
    input wire logic [1:0] zone_out,
    input wire logic zone_fault_out
);
    logic [15:0] run_q; // cycles the pin has been pulled low
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    // pull-low run length, cleared on release
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_q <= 16'h0000;
        end else begin
            run_q <= stat_oe_out ? run_q + 16'h0001 : 16'h0000;
        end
    end
    usb_start_a: assert property ($rose(resetn_in) |->
        input_limit_ma_out == 16'h0064) else $error("usb start limit");
    adp_start_a: assert property ($rose(resetn_in) && !source_usb_in
        |-> ##9 host_mode_out || input_limit_ma_out == 16'hFFFF)
        else $error("adapter start limit");
    // idle pulse only; a charge end also drops the pin
    pulse_len_a: assert property ($fell(stat_oe_out)
        && !$past(charging_in, 2) && $past(stat_enable_in)
        |-> run_q == FAULT_PULSE_CYC) else $error("pulse length");
    one_pulse_a: assert property ($fell(stat_oe_out) && fault_in
        && !charging_in |-> !stat_oe_out[*6]) else $error("pulse repeat");
    stat_off_a: assert property (!stat_enable_in |=>
        !stat_oe_out) else $error("pin driven while disabled");
    acc_follow_a: assert property (1'b1 |=>
        acc_switch_on_out == $past(acc_enable_in)) else $error("acc");
    cold_hot_a: assert property ((zone_out[1] && !host_mode_out)[*3]
        |-> charge_suspend_out) else $error("no suspend");
    warm_cut_a: assert property ((zone_out == 2'd1 && !host_mode_out)[*3]
        |-> charge_reduce_out && !charge_suspend_out) else $error("warm");
    zone_flag_a: assert property (zone_out != 2'd0 &&
        !zone_fault_clear_in |-> ##[0:2] zone_fault_out) else $error("flag");
    host_hands_a: assert property (host_mode_out && $past(host_mode_out)
        |-> !charge_suspend_out && !charge_reduce_out) else $error("host");
    lost_default_a: assert property (host_lost_in |=>
        !host_mode_out) else $error("lost host");
    cover property ($fell(stat_oe_out) && !charging_in);
    cover property (charge_suspend_out && zone_out == 2'd3);
    cover property ($fell(host_mode_out));
endmodule
bind csml_top csml_chk #(.FAULT_PULSE_CYC(FAULT_PULSE_CYC)) chk_u (.*);

// ### tb/csml_host.sv
// Purpose: host processor model on the status pin and control bits
// Assumes: the status pin has a board pull-up
// Notes: control bits stand in for serial register writes
`timescale 1ns/1ps
module csml_host (
    input wire logic clock_in,
    input wire logic stat_oe_in,
    output logic stat_pin_out,
    output logic stat_enable_out,
    output logic acc_enable_out,
    output logic host_programmed_out,
    output logic host_lost_out,
    output logic [15:0] host_ichg_ma_out,
    output logic [15:0] host_ilim_ma_out
);
    // a released pin floats up, never holds its last level
    assign stat_pin_out = stat_oe_in ? 1'b0 : 1'b1;
    initial begin
        {stat_enable_out, acc_enable_out} = 2'b00;
        {host_programmed_out, host_lost_out} = 2'b00;
        {host_ichg_ma_out, host_ilim_ma_out} = 32'h0000_0000;
    end
    task automatic set_ctrl(input logic en, input logic acc);
        @(posedge clock_in);
        stat_enable_out <= en;
        acc_enable_out <= acc;
    endtask
    // host takes over or drops away
    task automatic hostctl(input logic lost, input logic [31:0] cur);
        @(posedge clock_in);
        {host_ichg_ma_out, host_ilim_ma_out} <= cur;
        {host_lost_out, host_programmed_out} <= {lost, !lost};
        @(posedge clock_in);
        {host_lost_out, host_programmed_out} <= 2'b00;
    endtask
endmodule

// ### tb/csml_top_tb.sv
// Purpose: self-checking bench for the charger status logic
// Assumes: pulse parameter shortened to 8 cycles
// Notes: async inputs are given 8 cycles to land
`timescale 1ns/1ps
module csml_top_tb;
    logic clock_in, resetn_in, source_usb_in, charging_in, charge_done_in;
    logic charge_disabled_in, fault_in, above_cold_in, below_hot_in;
    logic below_warm_in, zone_fault_clear_in, stat_enable_in, acc_enable_in;
    logic host_programmed_in, host_lost_in, stat_out, stat_oe_out, pin;
    logic acc_switch_on_out, charge_suspend_out, charge_reduce_out;
    logic host_mode_out, zone_fault_out;
    logic [15:0] host_ichg_ma_in, host_ilim_ma_in;
    logic [15:0] input_limit_ma_out, charge_current_ma_out;
    logic [1:0] zone_out;
    logic [6:0] zt [5]; // cold hot warm, zone, suspend, reduce
    int num_errors = 0;
    int tests_run = 0;
    int n;
    csml_top #(.FAULT_PULSE_CYC(8)) dut_u (.*);
    csml_host host_u (.clock_in(clock_in), .stat_oe_in(stat_oe_out),
        .stat_pin_out(pin), .stat_enable_out(stat_enable_in),
        .acc_enable_out(acc_enable_in), .host_lost_out(host_lost_in),
        .host_programmed_out(host_programmed_in),
        .host_ichg_ma_out(host_ichg_ma_in), .host_ilim_ma_out(host_ilim_ma_in));
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(int k);
        repeat (k) @(negedge clock_in);
    endtask
    task automatic drv(logic [2:0] chg, logic [2:0] zn, logic [1:0] fc);
        @(posedge clock_in);
        {charging_in, charge_done_in, charge_disabled_in} <= chg;
        {above_cold_in, below_hot_in, below_warm_in} <= zn;
        {fault_in, zone_fault_clear_in} <= fc;
    endtask
    // pin cycles at one level over a window longer than a pulse
    task automatic span(logic lvl);
        n = 0;
        repeat (30) begin
            @(negedge clock_in);
            n += int'(pin === lvl);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    // a hang counts as a mismatch
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
    initial begin
        zt = '{7'b100_11_10, 7'b010_10_10, 7'b011_10_10, 7'b001_01_01, 0};
        {resetn_in, source_usb_in} = 2'b01;
        {charging_in, charge_done_in, charge_disabled_in, fault_in} = 4'h0;
        {above_cold_in, below_hot_in, below_warm_in} = 3'b000;
        zone_fault_clear_in = 1'b0;
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        wt(2);
        chk("ilim", 16'h0064, input_limit_ma_out);
        chk("ichg", 16'h01F4, charge_current_ma_out);
        chk("pin data", 0, 16'(stat_out));
        host_u.set_ctrl(1'b1, 1'b1);
        drv(3'b100, 0, 0);
        wt(3);
        chk("pin charging", 0, 16'(pin));
        chk("acc", 1, 16'(acc_switch_on_out));
        drv(3'b010, 0, 0);
        wt(3);
        chk("pin done", 1, 16'(pin));
        drv(3'b101, 0, 0);
        wt(3);
        chk("pin disabled", 1, 16'(pin));
        drv(3'b100, 0, 0);
        host_u.set_ctrl(1'b0, 1'b0);
        wt(3);
        chk("pin off", 1, 16'(pin));
        chk("acc off", 0, 16'(acc_switch_on_out));
        host_u.set_ctrl(1'b1, 1'b0);
        // end the charge first so the pin is idle before the fault
        drv(0, 0, 0);
        for (int i = 0; i < 2; i++) begin
            drv(0, 0, 2'b10);
            span(1'b0);
            chk("idle pulse", 8, 16'(n));
            drv(0, 0, 0);
            wt(8);
        end
        // pin already low from charging when the fault arrives
        drv(3'b100, 0, 0);
        drv(3'b100, 0, 2'b10);
        span(1'b1);
        chk("charge pulse", 8, 16'(n));
        for (int i = 0; i < 5; i++) begin
            drv(3'b100, zt[i][6:4], 0);
            wt(8);
            chk("zone", 16'(zt[i][3:2]), 16'(zone_out));
            chk("suspend", 16'(zt[i][1]), 16'(charge_suspend_out));
            chk("reduce", 16'(zt[i][0]), 16'(charge_reduce_out));
            chk("zone flag", 1, 16'(zone_fault_out));
        end
        drv(3'b100, 0, 2'b01);
        drv(3'b100, 0, 0);
        wt(2);
        chk("flag cleared", 0, 16'(zone_fault_out));
        host_u.hostctl(1'b0, 32'h02BC_01F4);
        drv(3'b100, 3'b100, 0);
        wt(8);
        chk("host mode", 1, 16'(host_mode_out));
        chk("host ichg", 16'h02BC, charge_current_ma_out);
        chk("host ilim", 16'h01F4, input_limit_ma_out);
        chk("host suspend", 0, 16'(charge_suspend_out));
        chk("host flag", 1, 16'(zone_fault_out));
        host_u.hostctl(1'b1, 0);
        wt(8);
        chk("default again", 0, 16'(host_mode_out));
        chk("suspend again", 1, 16'(charge_suspend_out));
        // second reset on an adapter source: strap must read low
        @(posedge clock_in);
        {resetn_in, source_usb_in} <= 2'b00;
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        wt(10);
        chk("adp ilim", 16'hFFFF, input_limit_ma_out);
        chk("adp ichg", 16'h03E8, charge_current_ma_out);
        close_out();
    end
endmodule
